// ### logic/fp_source_scoreboard.sv
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fp_source_scoreboard
	import fp_scoreboard_pkg::*;
(
	input  wire logic                 core_clk_i,
	input  wire logic                 rstn_i,
	input  wire logic                 ce_i,
	input  wire logic                 issue_valid_i,
	input  wire issue_op_t            issue_op_i,
	output logic                      issue_ready_o,
	input  wire logic [REG_COUNT-1:0] dst_busy_i,
	input  wire logic                 ex1_adv_i,
	input  wire logic                 bounce_i,
	input  wire logic                 support_done_i,
	output logic [REG_COUNT-1:0]      src_locks_o,
	output logic                      held_o,
	input  wire logic                 psel_i,
	input  wire logic                 penable_i,
	input  wire logic                 pwrite_i,
	input  wire logic [7:0]           paddr_i,
	input  wire logic [31:0]          pwdata_i,
	input  wire logic [3:0]           pstrb_i,
	output logic                      pready_o,
	output logic [31:0]               prdata_o,
	output logic                      pslverr_o
);

	function automatic logic [3:0] iter_count(input issue_op_t op);
		if (!op.is_vector) begin
			return 4'h1;
		end
		if (op.dbl) begin
			return {2'h0, op.vector_length_field[1:0]} + 4'h1;
		end
		return {1'b0, op.vector_length_field} + 4'h1;
	endfunction

	function automatic logic [REG_COUNT-1:0] reg_bit(input logic [4:0] base,
		input logic [2:0] k, input logic dbl);
		logic [2:0]           slot;
		logic [1:0]           dslot;
		logic [REG_COUNT-1:0] m;
		slot  = base[2:0] + k;
		dslot = base[1:0] + k[1:0];
		m = '0;
		if (dbl) begin
			m[{base[3:2], dslot, 1'b0}] = 1'b1;
			m[{base[3:2], dslot, 1'b1}] = 1'b1;
		end else begin
			m[{base[4:3], slot}] = 1'b1;
		end
		return m;
	endfunction

	function automatic logic [REG_COUNT-1:0] iter_mask(input issue_op_t op,
		input logic [2:0] k);
		logic [REG_COUNT-1:0] m;
		m = reg_bit(op.src_a, k, op.dbl);
		if (op.src_b_en) begin
			m = m | reg_bit(op.src_b, k, op.dbl);
		end
		if (op.is_mac) begin
			m = m | reg_bit(op.dst, k, op.dbl);
		end
		return m;
	endfunction

	function automatic logic strict_like(input held_op_t h);
		return !h.fast || h.op.store_multiple;
	endfunction

	function automatic logic [2:0] first_lock(input held_op_t h);
		if (strict_like(h)) begin
			return 3'h0;
		end
		return h.op.dbl ? DP_FAST_FIRST : SP_FAST_FIRST;
	endfunction

	function automatic logic iter_locked(input held_op_t h, input logic [2:0] k);
		if ({1'b0, k} >= iter_count(h.op)) begin
			return 1'b0;
		end
		if (strict_like(h)) begin
			return 1'b1;
		end
		if (h.op.is_store || !h.op.is_vector) begin
			return 1'b0;
		end
		return k >= first_lock(h);
	endfunction

	// Execute 1 cycle, counted from one, in which iteration k releases its sources
	function automatic logic [3:0] clear_cycle(input held_op_t h, input logic [2:0] k);
		logic [3:0] rel;
		logic [3:0] step;
		logic [3:0] start;
		rel   = {1'b0, k} - {1'b0, first_lock(h)};
		step  = h.op.two_cycle ? {rel[2:0], 1'b0} : rel;
		if (strict_like(h)) begin
			start = STRICT_START;
		end else if (h.op.dbl) begin
			start = DP_FAST_START;
		end else begin
			start = SP_FAST_START;
		end
		return step + start;
	endfunction

	track_state_t         state;
	track_state_t         next_state;
	held_op_t             held;
	held_op_t             next_held;
	held_op_t             new_h;
	logic [3:0]           ex1_cnt;
	logic [3:0]           next_cnt;
	logic [2:0]           iter_ptr;
	logic [2:0]           next_iter_ptr;
	logic                 fast_mode;
	logic [REG_COUNT-1:0] chk_acc [ITER_MAX+1];
	logic [REG_COUNT-1:0] src_acc [ITER_MAX+1];
	logic [REG_COUNT-1:0] set_acc [ITER_MAX+1];
	logic [REG_COUNT-1:0] set_mask;
	logic [REG_COUNT-1:0] clr_mask;
	logic [REG_COUNT-1:0] cur_mask;
	logic                 hazard;
	logic                 issue_go;
	logic                 ex1_step;
	logic [3:0]           cnt_step;
	logic                 clear_due;
	logic                 bounce_hit;
	logic                 clear_now;
	logic                 last_hit;

	assign new_h = {issue_op_i, fast_mode};

	// every iteration's registers join the hazard check, whatever the mode
	assign chk_acc[0] = '0;
	assign src_acc[0] = '0;
	assign set_acc[0] = '0;
	for (genvar k = 0; k < ITER_MAX; k++) begin : g_iter
		logic                 in_op;
		logic [REG_COUNT-1:0] srcs;
		logic [REG_COUNT-1:0] dsts;
		assign in_op = 4'(k) < iter_count(issue_op_i);
		assign srcs  = iter_mask(issue_op_i, 3'(k));
		assign dsts  = issue_op_i.dst_en ? reg_bit(issue_op_i.dst, 3'(k), issue_op_i.dbl) : '0;
		assign chk_acc[k+1] = chk_acc[k] | (in_op ? (srcs | dsts) : '0);
		assign src_acc[k+1] = src_acc[k] | (in_op ? srcs : '0);
		assign set_acc[k+1] = set_acc[k] | (iter_locked(new_h, 3'(k)) ? srcs : '0);
	end

	assign hazard        = (chk_acc[ITER_MAX] & (src_locks_o | dst_busy_i)) != '0;
	// one operation is tracked at a time; a second waits until the first has released
	assign issue_ready_o = ce_i && state == S_IDLE && !hazard;
	assign issue_go      = issue_valid_i && issue_ready_o;
	assign set_mask      = issue_go ? set_acc[ITER_MAX] : '0;

	assign ex1_step   = state == S_RUN && ex1_adv_i;
	assign cnt_step   = ex1_cnt + 4'h1;
	assign clear_due  = ex1_step && cnt_step == clear_cycle(held, iter_ptr);
	// the bounced iteration is reported in its own Execute 1 cycle, so its clear is held back
	assign bounce_hit = ex1_step && bounce_i && !held.fast;
	assign clear_now  = clear_due && !bounce_hit;
	assign cur_mask   = iter_mask(held.op, iter_ptr);
	assign last_hit   = {1'b0, iter_ptr} == iter_count(held.op) - 4'h1;
	assign held_o     = state == S_HELD;

	always_comb begin
		clr_mask = '0;
		if (clear_now) begin
			clr_mask = cur_mask;
		end else if (state == S_HELD && support_done_i) begin
			clr_mask = '1;
		end
	end

	always_comb begin
		next_state    = state;
		next_held     = held;
		next_cnt      = ex1_cnt;
		next_iter_ptr = iter_ptr;
		unique case (state)
			S_IDLE: begin
				if (issue_go) begin
					next_held     = new_h;
					next_cnt      = '0;
					next_iter_ptr = first_lock(new_h);
					if (set_acc[ITER_MAX] != '0) begin
						next_state = S_RUN;
					end
				end
			end
			S_RUN: begin
				if (bounce_hit) begin
					next_state = S_HELD;
				end else if (ex1_step) begin
					next_cnt = cnt_step;
					if (clear_due) begin
						next_iter_ptr = iter_ptr + 3'h1;
						if (last_hit) begin
							next_state = S_IDLE;
						end
					end
				end
			end
			S_HELD: begin
				if (support_done_i) begin
					next_state = S_IDLE;
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state    <= S_IDLE;
			held     <= '0;
			ex1_cnt  <= '0;
			iter_ptr <= '0;
		end else if (ce_i) begin
			state    <= next_state;
			held     <= next_held;
			ex1_cnt  <= next_cnt;
			iter_ptr <= next_iter_ptr;
		end
	end

	lock_bank #(
		.WIDTH(REG_COUNT)
	) u_locks (
		.core_clk_i(core_clk_i),
		.rstn_i    (rstn_i),
		.ce_i      (ce_i),
		.set_i     (set_mask),
		.clr_i     (clr_mask),
		.locks_o   (src_locks_o)
	);

	// register access; a zero-wait slave that stalls only while the clock enable is low
	logic        apb_setup;
	logic        apb_write;
	logic        hit_ctrl;
	logic        hit_locks;
	logic        hit_status;
	logic        unmapped;
	logic [31:0] status_word;
	logic [31:0] rd_data;

	assign pready_o   = ce_i;
	assign apb_setup  = psel_i && !penable_i && ce_i;
	assign apb_write  = psel_i && penable_i && pwrite_i && ce_i;
	assign hit_ctrl   = paddr_i == CTRL_OFFSET;
	assign hit_locks  = paddr_i == LOCKS_OFFSET;
	assign hit_status = paddr_i == STATUS_OFFSET;
	assign unmapped   = !(hit_ctrl || hit_locks || hit_status);

	always_comb begin
		status_word                               = '0;
		status_word[STAT_BUSY_BIT]                = state != S_IDLE;
		status_word[STAT_HELD_BIT]                = state == S_HELD;
		status_word[STAT_PTR_LSB +: 3]            = iter_ptr;
		status_word[STAT_CNT_LSB +: 4]            = ex1_cnt;
	end

	assign rd_data = hit_ctrl ? 32'(fast_mode) << CTRL_FAST_BIT :
		hit_locks ? src_locks_o :
		hit_status ? status_word : 32'h0000_0000;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prdata_o  <= '0;
			pslverr_o <= 1'b0;
			fast_mode <= CTRL_FAST_RST;
		end else begin
			if (apb_setup) begin
				prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_data;
				pslverr_o <= unmapped || (pwrite_i && !hit_ctrl);
			end
			// takes effect for the next issued operation only
			if (apb_write && hit_ctrl && pstrb_i[0]) begin
				fast_mode <= pwdata_i[CTRL_FAST_BIT];
			end
		end
	end

	property p_fast_scalar_free;
		@(posedge core_clk_i) disable iff (!rstn_i)
		issue_go && fast_mode && !issue_op_i.store_multiple &&
			(!issue_op_i.is_vector || issue_op_i.is_store) |=> src_locks_o == '0;
	endproperty
	a_fast_scalar_free: assert property (p_fast_scalar_free) else $error("fast scalar locked");

	property p_fast_sp_short;
		@(posedge core_clk_i) disable iff (!rstn_i)
		issue_go && fast_mode && !issue_op_i.dbl && !issue_op_i.store_multiple &&
			issue_op_i.vector_length_field < 3'h4 |=> src_locks_o == '0 && state == S_IDLE;
	endproperty
	a_fast_sp_short: assert property (p_fast_sp_short) else $error("short single vector locked");

	property p_fast_dp_short;
		@(posedge core_clk_i) disable iff (!rstn_i)
		issue_go && fast_mode && issue_op_i.dbl && !issue_op_i.store_multiple &&
			issue_op_i.vector_length_field[1:0] < 2'h2 |=> src_locks_o == '0;
	endproperty
	a_fast_dp_short: assert property (p_fast_dp_short) else $error("short double vector locked");

	property p_strict_all;
		@(posedge core_clk_i) disable iff (!rstn_i)
		issue_go && !fast_mode |=> src_locks_o == $past(src_acc[ITER_MAX]);
	endproperty
	a_strict_all: assert property (p_strict_all) else $error("strict issue lock mismatch");

	property p_stall_hold;
		@(posedge core_clk_i) disable iff (!rstn_i)
		ce_i && state == S_IDLE && issue_valid_i && hazard |=>
			src_locks_o == $past(src_locks_o) && state == S_IDLE;
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("stalled issue updated locks");

	property p_strict_first;
		@(posedge core_clk_i) disable iff (!rstn_i)
		ce_i && state == S_RUN && !held.fast && !held.op.store_multiple && ex1_adv_i &&
			!bounce_i && ex1_cnt == 4'h0 |=> (src_locks_o & $past(cur_mask)) == '0;
	endproperty
	a_strict_first: assert property (p_strict_first) else $error("iteration one not cleared");

	property p_fast_sp_wait;
		@(posedge core_clk_i) disable iff (!rstn_i)
		ce_i && state == S_RUN && held.fast && !held.op.dbl && !held.op.store_multiple &&
			ex1_adv_i && ex1_cnt == 4'h0 |=> $stable(src_locks_o) ##0 src_locks_o != '0;
	endproperty
	a_fast_sp_wait: assert property (p_fast_sp_wait) else $error("cleared in first cycle");

	property p_dp_two_gap;
		@(posedge core_clk_i) disable iff (!rstn_i)
		ce_i && state == S_RUN && held.op.dbl && held.op.two_cycle && ex1_adv_i &&
			!bounce_i && ex1_cnt == 4'h1 |=> $stable(src_locks_o);
	endproperty
	a_dp_two_gap: assert property (p_dp_two_gap) else $error("cleared in even cycle");

	property p_bounce_hold;
		@(posedge core_clk_i) disable iff (!rstn_i)
		ce_i && bounce_hit |=> state == S_HELD && src_locks_o == $past(src_locks_o);
	endproperty
	a_bounce_hold: assert property (p_bounce_hold) else $error("bounce released locks");

	property p_held_stable;
		@(posedge core_clk_i) disable iff (!rstn_i)
		state == S_HELD && !support_done_i |=> $stable(src_locks_o);
	endproperty
	a_held_stable: assert property (p_held_stable) else $error("held locks changed");

	property p_latched;
		@(posedge core_clk_i) disable iff (!rstn_i)
		state != S_IDLE |=> $stable(held);
	endproperty
	a_latched: assert property (p_latched) else $error("operation fields changed");

endmodule

// ### logic/lock_bank.sv
`timescale 1ns/1ps
module lock_bank #(
	parameter int WIDTH = 32
) (
	input  wire logic             core_clk_i,
	input  wire logic             rstn_i,
	input  wire logic             ce_i,
	input  wire logic [WIDTH-1:0] set_i,
	input  wire logic [WIDTH-1:0] clr_i,
	output logic      [WIDTH-1:0] locks_o
);

	// a lock set in the same cycle as a clear survives
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			locks_o <= '0;
		end else if (ce_i) begin
			locks_o <= (locks_o & ~clr_i) | set_i;
		end
	end

endmodule

// ### pkg/fp_scoreboard_pkg.sv
package fp_scoreboard_pkg;

	localparam int REG_COUNT = 32;
	localparam int ITER_MAX  = 8;

	// zero-based first locked iteration in fast mode; first clearing Execute 1 cycle, counted from one, in fast and strict mode
	localparam logic [2:0] SP_FAST_FIRST = 3'h4;
	localparam logic [2:0] DP_FAST_FIRST = 3'h2;
	localparam logic [3:0] SP_FAST_START = 4'h2;
	localparam logic [3:0] DP_FAST_START = 4'h1;
	localparam logic [3:0] STRICT_START  = 4'h1;

	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] LOCKS_OFFSET  = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam int         CTRL_FAST_BIT = 0;
	localparam logic       CTRL_FAST_RST = 1'b0;
	localparam int         STAT_BUSY_BIT = 0;
	localparam int         STAT_HELD_BIT = 1;
	localparam int         STAT_PTR_LSB  = 4;
	localparam int         STAT_CNT_LSB  = 8;

	typedef struct packed {
		logic       dbl;
		logic       is_vector;
		logic [2:0] vector_length_field;
		logic       two_cycle;
		logic       is_mac;
		logic       is_store;
		logic       store_multiple;
		logic       src_b_en;
		logic       dst_en;
		logic [4:0] src_a;
		logic [4:0] src_b;
		logic [4:0] dst;
	} issue_op_t;

	typedef struct packed {
		issue_op_t op;
		logic      fast;
	} held_op_t;

	typedef enum logic [1:0] {S_IDLE, S_RUN, S_HELD} track_state_t;

endpackage

// ### test/issue_ctrl_model.sv
`timescale 1ns/1ps
module issue_ctrl_model
	import fp_scoreboard_pkg::*;
(
	input  wire logic      core_clk_i,
	input  wire logic      rstn_i,
	input  wire logic      go_i,
	input  wire logic      run_i,
	input  wire logic      stop_i,
	input  wire logic      bounce_req_i,
	input  wire issue_op_t op_i,
	input  wire logic      ready_i,
	output logic           issue_valid_o,
	output issue_op_t      issue_op_o,
	output logic           ex1_adv_o,
	output logic           bounce_o,
	output logic           busy_o
);
	// op held until taken; afterwards the bus is scrambled so nothing leans on stale fields
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			issue_valid_o <= 1'b0;
			issue_op_o    <= '0;
			ex1_adv_o     <= 1'b0;
			busy_o        <= 1'b0;
		end else begin
			if (issue_valid_o && ready_i) begin
				issue_valid_o <= 1'b0;
				issue_op_o    <= ~issue_op_o;
				busy_o        <= 1'b1;
			end else if (go_i && !issue_valid_o && !busy_o) begin
				issue_valid_o <= 1'b1;
				issue_op_o    <= op_i;
			end
			if (stop_i)
				busy_o <= 1'b0;
			// run_i low models execute stalls between Execute 1 cycles
			ex1_adv_o <= busy_o && run_i;
		end
	end
	assign bounce_o = ex1_adv_o && bounce_req_i;
endmodule

// ### test/test_fp_source_scoreboard.sv
`timescale 1ns/1ps
module test_fp_source_scoreboard;
	import fp_scoreboard_pkg::*;
	logic        core_clk_i = 0, rstn_i = 0, go = 0, run = 0, stop = 0, breq = 0, sdone = 0;
	logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, valid, ready;
	logic        adv, bounce, busy, held_w, hold, ce = 1;
	logic [7:0]  paddr = '0;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] pwdata = '0, prdata, rd, locks, dst_busy = '0, seed = 32'hEF6083E6;
	issue_op_t   op = '0, bus_op;
	int          n_mismatch = 0, tests_run = 0;

	always #5 core_clk_i = ~core_clk_i;

	issue_ctrl_model issue_ctrl_model_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .go_i(go),
		.run_i(run), .stop_i(stop), .bounce_req_i(breq), .op_i(op), .ready_i(ready),
		.issue_valid_o(valid), .issue_op_o(bus_op), .ex1_adv_o(adv), .bounce_o(bounce),
		.busy_o(busy));
	fp_source_scoreboard fp_source_scoreboard_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.ce_i(ce), .issue_valid_i(valid), .issue_op_i(bus_op), .issue_ready_o(ready),
		.dst_busy_i(dst_busy), .ex1_adv_i(adv), .bounce_i(bounce), .support_done_i(sdone),
		.src_locks_o(locks), .held_o(held_w), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// double register d occupies single bits 2d and 2d+1; iterations wrap inside the bank
	function automatic logic [31:0] rbits(logic [4:0] b, logic d, logic [2:0] k);
		logic [4:0] r;
		r = d ? {b[3:2], 2'(b[1:0] + k[1:0]), 1'b0} : {b[4:3], 3'(b[2:0] + k)};
		return d ? 32'h3 << r : 32'h1 << r;
	endfunction

	function automatic logic [31:0] exp_mask(issue_op_t o, logic f, int cnt);
		logic [31:0] m;
		int n, t, first, st;
		logic sf;
		m = '0;
		n = 1;
		if (o.is_vector)
			n = (o.dbl ? int'(o.vector_length_field[1:0]) : int'(o.vector_length_field)) + 1;
		// store-multiple keeps strict locking in fast mode; other fast stores lock nothing
		sf = f && !o.store_multiple;
		if (sf && o.is_store)
			n = 0;
		t = o.two_cycle ? 2 : 1;
		first = sf ? (o.dbl ? 2 : 4) : 0;
		st = (sf && !o.dbl) ? 2 : 1;
		for (int k = first; k < n; k++)
			if ((k - first) * t + st > cnt)
				m |= rbits(o.src_a, o.dbl, 3'(k)) | (o.src_b_en ? rbits(o.src_b, o.dbl, 3'(k)) : '0)
					| (o.is_mac ? rbits(o.dst, o.dbl, 3'(k)) : '0);
		return m;
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge core_clk_i);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge core_clk_i);
		penable <= 1;
		do begin
			@(posedge core_clk_i);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task run_op(input logic f, input int bb);
		int cnt, i;
		logic [31:0] e;
		apb(1, CTRL_OFFSET, {31'h0, f}, 4'hF);
		@(posedge core_clk_i);
		go <= 1;
		run <= 0;
		do begin
			@(posedge core_clk_i);
		end while (busy !== 1'b1);
		go <= 0;
		// mode flips after issue; the tracked op keeps its latched mode
		apb(1, CTRL_OFFSET, {31'h0, !f}, 4'hF);
		cnt = 0;
		hold = 0;
		// room for eight two-cycle iterations with random execute stalls
		for (i = 0; i < 64; i++) begin
			@(posedge core_clk_i);
			if (adv && !hold) begin
				cnt++;
				hold = bounce;
			end
			breq <= bb != 0 && cnt == bb - 1;
			run <= bb != 0 || (xs() & 3) != 0;
			#1;
			e = exp_mask(op, f, hold ? bb - 1 : cnt);
			chk(locks, e, "locks");
			chk({31'h0, held_w}, {31'h0, hold}, "held");
			if (e == 0 && !hold)
				break;
		end
		if (hold) begin
			apb(0, LOCKS_OFFSET, 0, 4'hF);
			chk(rd, e, "held locks");
			// one-cycle strict op: bounce in cycle bb leaves pointer and count at bb-1
			e = (32'h1 << STAT_BUSY_BIT) | (32'h1 << STAT_HELD_BIT);
			e |= (32'(bb - 1) << STAT_PTR_LSB) | (32'(bb - 1) << STAT_CNT_LSB);
			apb(0, STATUS_OFFSET, 0, 4'hF);
			chk(rd, e, "status");
			@(posedge core_clk_i);
			sdone <= 1;
			@(posedge core_clk_i);
			sdone <= 0;
			@(posedge core_clk_i);
			#1;
			chk(locks, 32'h0, "release");
			chk({31'h0, held_w}, 32'h0, "unheld");
		end
		chk({31'h0, ready}, 32'h1, "ready");
		@(posedge core_clk_i);
		stop <= 1;
		@(posedge core_clk_i);
		stop <= 0;
		$display("op test %0d done", tests_run);
	endtask

	task rand_op();
		logic [31:0] r;
		r = xs();
		op = '0;
		op.dbl = r[0];
		op.is_vector = r[1];
		op.vector_length_field = r[0] ? {1'b0, r[3:2]} : r[4:2];
		op.two_cycle = r[5];
		op.is_mac = r[6];
		op.is_store = r[17];
		op.store_multiple = r[17] & r[18];
		op.src_b_en = r[7];
		op.dst_en = 1;
		op.src_a = r[0] ? {3'b001, r[9:8]} : {2'b01, r[10:8]};
		op.src_b = r[0] ? {3'b010, r[12:11]} : {2'b10, r[13:11]};
		op.dst = r[0] ? {3'b011, r[15:14]} : {2'b11, r[16:14]};
	endtask

	task finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#500000;
		n_mismatch++;
		finish_test();
	end

	initial begin
		repeat (3) @(posedge core_clk_i);
		rstn_i <= 1;
		apb(0, CTRL_OFFSET, 0, 4'hF);
		chk(rd, 32'h0, "ctrl reset");
		apb(1, CTRL_OFFSET, 1, 4'h0);
		apb(0, CTRL_OFFSET, 0, 4'hF);
		chk(rd, 32'h0, "strobe off");
		apb(0, 8'h0C, 0, 4'hF);
		chk({rd[30:0], err}, 32'h1, "unmapped");
		apb(1, LOCKS_OFFSET, 32'hFFFFFFFF, 4'hF);
		chk({31'h0, err}, 32'h1, "ro write");
		ce <= 0;
		@(posedge core_clk_i);
		#1;
		chk({30'h0, ready, pready}, 32'h0, "ce low");
		@(posedge core_clk_i);
		ce <= 1;
		$display("register test done");
		rand_op();
		dst_busy <= rbits(op.src_a, op.dbl, 3'h0);
		go <= 1;
		repeat (6) @(posedge core_clk_i);
		#1;
		chk({30'h0, ready, busy}, 32'h0, "stall");
		@(posedge core_clk_i);
		dst_busy <= '0;
		run_op(0, 0);
		op = '0;
		op.is_vector = 1;
		op.vector_length_field = 3'h3;
		op.is_mac = 1;
		op.src_b_en = 1;
		op.src_a = 5'h0A;
		op.src_b = 5'h12;
		op.dst = 5'h1F;
		run_op(0, 2);
		repeat (40) begin
			rand_op();
			run_op(xs() > 32'h7FFFFFFF, 0);
		end
		finish_test();
	end
endmodule
